// ---- rtl/irwd_consts.svh ----
// constants of the ir remote wake decoder: offsets, fields, reset values, timing
`ifndef IRWD_CONSTS_SVH
`define IRWD_CONSTS_SVH

`define IRWD_CLK_NS 10
`define IRWD_TICK_NS 1000
`define IRWD_TICK_CYC ((`IRWD_TICK_NS + `IRWD_CLK_NS - 1) / `IRWD_CLK_NS)
`define IRWD_WAKE_NS 10000
`define IRWD_WAKE_CYC ((`IRWD_WAKE_NS + `IRWD_CLK_NS - 1) / `IRWD_CLK_NS)
`define IRWD_BLINK_NS 50000000
`define IRWD_BLINK_CYC ((`IRWD_BLINK_NS + `IRWD_CLK_NS - 1) / `IRWD_CLK_NS)

`define IRWD_NCFG 11
`define IRWD_OFF_CTRL 8'h00
`define IRWD_OFF_FIELD 8'h04
`define IRWD_OFF_ADDR 8'h08
`define IRWD_OFF_CMD_LO 8'h0C
`define IRWD_OFF_CMD_HI 8'h10
`define IRWD_OFF_CMD_EN 8'h14
`define IRWD_OFF_HDR_MARK 8'h18
`define IRWD_OFF_HDR_SPACE 8'h1C
`define IRWD_OFF_BIT_T 8'h20
`define IRWD_OFF_SPACE1 8'h24
`define IRWD_OFF_MARGIN 8'h28
`define IRWD_OFF_STATUS 8'h2C
`define IRWD_OFF_INT_STAT 8'h30
`define IRWD_OFF_INT_MASK 8'h34

`define IRWD_CTRL_EN 0
`define IRWD_CTRL_PHASE 1
`define IRWD_CTRL_HDR 2
`define IRWD_CTRL_INV 3
`define IRWD_CTRL_CMD_FIRST 4
`define IRWD_CTRL_LED_EN 5
`define IRWD_CTRL_LED_ADDR 6
`define IRWD_INT_WAKE 0
`define IRWD_INT_BLINK 1
`define IRWD_INT_ERR 2

`define IRWD_RST_CTRL 32'h0000_0025
`define IRWD_RST_FIELD 32'h0000_0810
`define IRWD_RST_ADDR 32'h0000_0000
`define IRWD_RST_CMD_LO 32'h0000_0000
`define IRWD_RST_CMD_HI 32'h0000_0000
`define IRWD_RST_CMD_EN 32'h0000_0001
`define IRWD_RST_HDR_MARK 32'h0000_0800
`define IRWD_RST_HDR_SPACE 32'h0000_0400
`define IRWD_RST_BIT_T 32'h0000_0100
`define IRWD_RST_SPACE1 32'h0000_0300
`define IRWD_RST_MARGIN 32'h0000_0040

`endif

// ---- rtl/irwd_pkg.sv ----
// types of the ir remote wake decoder
`include "irwd_consts.svh"
package irwd_pkg;
  typedef enum logic [3:0] {
    IRWD_ST_IDLE = 4'b0001,
    IRWD_ST_HDR = 4'b0010,
    IRWD_ST_DATA = 4'b0100,
    IRWD_ST_DONE = 4'b1000
  } irwd_state_e;

  typedef logic [`IRWD_NCFG-1:0][31:0] irwd_cfg_t;

  typedef struct packed {
    logic [15:0] tick;
    logic [15:0] len;
    logic level;
    logic idle_sent;
    logic valid;
    logic mark;
    logic [15:0] out_len;
    logic idle;
  } irwd_meas_s;

  typedef struct packed {
    logic [3:0] idx;
    logic busy;
    logic we;
    logic done;
  } irwd_load_s;

  typedef struct packed {
    irwd_cfg_t cfg;
    logic [2:0] int_stat;
    logic [2:0] int_mask;
    irwd_state_e st;
    logic [23:0] shreg;
    logic [4:0] nbits;
    logic have_half;
    logic first_mark;
    logic pend_mark;
    logic [2:0] last_cmd;
    logic last_hit;
    logic [15:0] wake_cnt;
    logic [31:0] led_cnt;
    logic wake;
    logic led;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } irwd_top_s;
endpackage : irwd_pkg

// ---- rtl/irwd_ifs.sv ----
// interfaces between the decoder core, the interval meter and the config loader
`timescale 1ns/1ns
interface irwd_seg_if;
  logic valid;
  logic mark;
  logic [15:0] len;
  logic idle;
  logic [15:0] limit;
  modport src (output valid, output mark, output len, output idle, input limit);
  modport dst (input valid, input mark, input len, input idle, output limit);
endinterface : irwd_seg_if

interface irwd_ld_if;
  logic we;
  logic [3:0] idx;
  logic [31:0] data;
  logic done;
  modport src (output we, output idx, output data, output done);
  modport dst (input we, input idx, input data, input done);
endinterface : irwd_ld_if

// ---- rtl/irwd_meas.sv ----
// measures mark and space intervals of the demodulated ir input in ticks
`timescale 1ns/1ns
module irwd_meas #(
  parameter int TICK_CYC = `IRWD_TICK_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ir_mark_in,
  irwd_seg_if.src seg
);
  import irwd_pkg::*;
  irwd_meas_s q, d;

  always_comb
  begin
    d = q;
    d.valid = 1'b0;
    d.idle = 1'b0;
    d.tick = q.tick + 16'h0001;
    if (q.tick >= 16'(TICK_CYC - 1))
    begin
      d.tick = 16'h0000;
    end
    if (ir_mark_in != q.level)
    begin
      // interval ended: carrier present means mark
      d.valid = 1'b1;
      d.mark = q.level;
      d.out_len = q.len;
      d.len = 16'h0000;
      d.tick = 16'h0000;
      d.level = ir_mark_in;
      d.idle_sent = 1'b0;
    end
    else if (q.tick >= 16'(TICK_CYC - 1))
    begin
      if (q.len != 16'hFFFF)
      begin
        d.len = q.len + 16'h0001;
      end
      if (!q.level && !q.idle_sent && q.len >= seg.limit)
      begin
        d.idle = 1'b1;
        d.idle_sent = 1'b1;
        d.out_len = q.len;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '{default: '0, idle_sent: 1'b1};
    end
    else
    begin
      q <= d;
    end
  end

  assign seg.valid = q.valid;
  assign seg.mark = q.mark;
  assign seg.len = q.out_len;
  assign seg.idle = q.idle;
endmodule : irwd_meas

// ---- rtl/irwd_loader.sv ----
// copies the stored configuration image into the working registers after reset
`timescale 1ns/1ns
module irwd_loader #(
  parameter irwd_pkg::irwd_cfg_t IMAGE = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  irwd_ld_if.src ld
);
  import irwd_pkg::*;
  irwd_load_s q, d;

  always_comb
  begin
    d = q;
    d.we = q.busy;
    if (q.busy)
    begin
      d.idx = q.idx + 4'h1;
      if (q.idx == 4'(`IRWD_NCFG - 1))
      begin
        d.busy = 1'b0;
      end
    end
    d.done = q.we && !q.busy;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '{default: '0, busy: 1'b1};
    end
    else
    begin
      q <= d;
    end
  end

  assign ld.we = q.we;
  assign ld.idx = q.idx - 4'h1;
  assign ld.data = IMAGE[q.idx - 4'h1];
  assign ld.done = q.done || (!q.busy && !q.we);
endmodule : irwd_loader

// ---- rtl/irwd_top.sv ----
// ir remote wake decoder: apb registers, frame decoder, wake pulse and led blink
`timescale 1ns/1ns
module irwd_top #(
  parameter int WAKE_CYC = `IRWD_WAKE_CYC,
  parameter int BLINK_CYC = `IRWD_BLINK_CYC,
  parameter int TICK_CYC = `IRWD_TICK_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ir_mark_in,
  output logic system_wake_pulse,
  output logic power_led,
  output logic irq
);
  import irwd_pkg::*;

  localparam irwd_cfg_t NVM_IMAGE = {`IRWD_RST_MARGIN, `IRWD_RST_SPACE1, `IRWD_RST_BIT_T,
    `IRWD_RST_HDR_SPACE, `IRWD_RST_HDR_MARK, `IRWD_RST_CMD_EN, `IRWD_RST_CMD_HI,
    `IRWD_RST_CMD_LO, `IRWD_RST_ADDR, `IRWD_RST_FIELD, `IRWD_RST_CTRL};

  irwd_top_s q, d;
  irwd_seg_if seg ();
  irwd_ld_if ld ();

  irwd_meas #(.TICK_CYC(TICK_CYC)) u_meas (
    .pclk(pclk),
    .presetn(presetn),
    .ir_mark_in(ir_mark_in),
    .seg(seg.src)
  );

  irwd_loader #(.IMAGE(NVM_IMAGE)) u_loader (
    .pclk(pclk),
    .presetn(presetn),
    .ld(ld.src)
  );

  function automatic logic [31:0] cfg_mask(input logic [3:0] idx);
    case (idx)
      4'h0: cfg_mask = 32'h0000_007F;
      4'h1: cfg_mask = 32'h0000_0F1F;
      4'h3, 4'h4: cfg_mask = 32'hFFFF_FFFF;
      4'h5: cfg_mask = 32'h0000_00FF;
      default: cfg_mask = 32'h0000_FFFF;
    endcase
  endfunction : cfg_mask

  function automatic logic in_win(input logic [15:0] len, input logic [15:0] nom, input logic [15:0] mrg);
    in_win = ({1'b0, len} + {1'b0, mrg} >= {1'b0, nom}) && ({1'b0, len} <= {1'b0, nom} + {1'b0, mrg});
  endfunction : in_win

  logic [31:0] ctrl;
  logic [4:0] alen;
  logic [4:0] clen;
  logic [4:0] total;
  logic [15:0] amask;
  logic [7:0] cmask;
  logic [15:0] bit_t;
  logic [15:0] two_t;
  logic [15:0] mrg;
  logic run;
  logic err;
  logic data_seg;
  logic bitv;
  logic [1:0] halves;
  logic [15:0] addr_rx;
  logic [7:0] cmd_rx;
  logic addr_ok;
  logic cmd_ok;
  logic [2:0] cmd_idx;
  logic [7:0] code;
  logic [5:0] ridx;
  logic [31:0] rdata;
  logic rvalid;
  logic wr;
  logic [16:0] lim;
  logic [2:0] ev;

  always_comb
  begin
    d = q;
    ctrl = q.cfg[0];
    // lengths clamp into 1..16 and 1..8
    alen = (q.cfg[1][4:0] == 5'd0) ? 5'd1 : ((q.cfg[1][4:0] > 5'd16) ? 5'd16 : q.cfg[1][4:0]);
    clen = (q.cfg[1][11:8] == 4'd0) ? 5'd1 : ((q.cfg[1][11:8] > 4'd8) ? 5'd8 : {1'b0, q.cfg[1][11:8]});
    total = alen + clen;
    amask = 16'((32'h0000_0001 << alen) - 32'h0000_0001);
    cmask = 8'((16'h0001 << clen) - 16'h0001);
    bit_t = q.cfg[8][15:0];
    two_t = 16'({1'b0, bit_t} << 1);
    mrg = q.cfg[10][15:0];
    // silence longer than any legal space ends the frame
    lim = ctrl[`IRWD_CTRL_PHASE] ? ({1'b0, two_t} + {1'b0, mrg}) : ({1'b0, q.cfg[9][15:0]} + {1'b0, mrg});
    if ({1'b0, q.cfg[7][15:0]} + {1'b0, mrg} > lim)
    begin
      lim = {1'b0, q.cfg[7][15:0]} + {1'b0, mrg};
    end
    seg.limit = (lim[16] || lim[15:0] == 16'hFFFF) ? 16'hFFFF : lim[15:0] + 16'h0001;
    run = ld.done && ctrl[`IRWD_CTRL_EN];
    err = 1'b0;
    data_seg = 1'b0;
    bitv = 1'b0;
    halves = 2'd0;
    addr_rx = 16'h0000;
    cmd_rx = 8'h00;
    addr_ok = 1'b0;
    cmd_ok = 1'b0;
    cmd_idx = 3'd0;
    code = 8'h00;
    ev = 3'h0;

    // working registers filled from the stored image
    if (ld.we)
      d.cfg[ld.idx] = ld.data & cfg_mask(ld.idx);

    if (!run)
      d.st = IRWD_ST_IDLE;
    else if (seg.valid)
    begin
      case (q.st)
        IRWD_ST_IDLE:
        begin
          if (seg.mark)
          begin
            d.nbits = 5'd0;
            d.have_half = 1'b0;
            d.pend_mark = 1'b0;
            if (ctrl[`IRWD_CTRL_HDR])
            begin
              if (in_win(seg.len, q.cfg[6][15:0], mrg))
              begin
                d.st = IRWD_ST_HDR;
              end
              else
              begin
                err = 1'b1;
              end
            end
            else
            begin
              d.st = IRWD_ST_DATA;
              data_seg = 1'b1;
            end
          end
        end
        IRWD_ST_HDR:
        begin
          if (!seg.mark && in_win(seg.len, q.cfg[7][15:0], mrg))
          begin
            d.st = IRWD_ST_DATA;
          end
          else
          begin
            err = 1'b1;
          end
        end
        IRWD_ST_DATA: data_seg = 1'b1;
        IRWD_ST_DONE: d.st = IRWD_ST_DONE;
        default: d.st = IRWD_ST_IDLE;
      endcase
    end
    else if (seg.idle)
    begin
      case (q.st)
        IRWD_ST_DATA:
        begin
          // trailing space half of the last phase bit is swallowed by the silence
          if (ctrl[`IRWD_CTRL_PHASE] && q.have_half && q.first_mark && (q.nbits + 5'd1 == total))
          begin
            d.shreg = {q.shreg[22:0], ~ctrl[`IRWD_CTRL_INV]};
            d.nbits = q.nbits + 5'd1;
            d.have_half = 1'b0;
          end
          else
          begin
            err = 1'b1;
          end
        end
        IRWD_ST_HDR: err = 1'b1;
        IRWD_ST_DONE: d.st = IRWD_ST_IDLE;
        IRWD_ST_IDLE: d.st = IRWD_ST_IDLE;
        default: d.st = IRWD_ST_IDLE;
      endcase
    end

    if (data_seg)
    begin
      if (ctrl[`IRWD_CTRL_PHASE])
      begin
        // each interval holds one or two equal halves
        if (in_win(seg.len, bit_t, mrg))
        begin
          halves = 2'd1;
        end
        else if (in_win(seg.len, two_t, mrg))
        begin
          halves = 2'd2;
        end
        else
        begin
          err = 1'b1;
        end
        for (int i = 0; i < 2; i++)
        begin
          if (i < int'(halves))
          begin
            if (!d.have_half)
            begin
              d.have_half = 1'b1;
              d.first_mark = seg.mark;
            end
            else if (d.first_mark != seg.mark)
            begin
              // one mark paired with one space, order gives the value
              d.shreg = {d.shreg[22:0], d.first_mark ^ ctrl[`IRWD_CTRL_INV]};
              d.nbits = d.nbits + 5'd1;
              d.have_half = 1'b0;
            end
            else
            begin
              err = 1'b1;
            end
          end
        end
      end
      else if (seg.mark)
      begin
        if (in_win(seg.len, bit_t, mrg) && !d.pend_mark)
        begin
          d.pend_mark = 1'b1;
        end
        else
        begin
          err = 1'b1;
        end
      end
      else
      begin
        if (!d.pend_mark)
        begin
          err = 1'b1;
        end
        else if (in_win(seg.len, bit_t, mrg))
        begin
          bitv = 1'b0;
          d.shreg = {d.shreg[22:0], bitv};
          d.nbits = d.nbits + 5'd1;
        end
        else if (in_win(seg.len, q.cfg[9][15:0], mrg))
        begin
          bitv = 1'b1;
          d.shreg = {d.shreg[22:0], bitv};
          d.nbits = d.nbits + 5'd1;
        end
        else
        begin
          err = 1'b1;
        end
        d.pend_mark = 1'b0;
      end
    end

    if (!err && d.st == IRWD_ST_DATA && d.nbits == total)
    begin
      // first received field sits in the upper bits
      if (ctrl[`IRWD_CTRL_CMD_FIRST])
      begin
        addr_rx = d.shreg[15:0] & amask;
        cmd_rx = 8'(d.shreg >> alen) & cmask;
      end
      else
      begin
        cmd_rx = d.shreg[7:0] & cmask;
        addr_rx = 16'(d.shreg >> clen) & amask;
      end
      addr_ok = (addr_rx == (q.cfg[2][15:0] & amask));
      for (int k = 0; k < 8; k++)
      begin
        code = (k < 4) ? q.cfg[3][8*(k%4) +: 8] : q.cfg[4][8*(k%4) +: 8];
        if (q.cfg[5][k] && !cmd_ok && ((code & cmask) == cmd_rx))
        begin
          cmd_ok = 1'b1;
          cmd_idx = 3'(k);
        end
      end
      // a frame closed by the silence has already had its gap
      d.st = seg.idle ? IRWD_ST_IDLE : IRWD_ST_DONE;
      d.last_hit = addr_ok && cmd_ok;
      d.last_cmd = cmd_idx;
      if (addr_ok && cmd_ok)
      begin
        d.wake_cnt = 16'(WAKE_CYC);
        ev[`IRWD_INT_WAKE] = 1'b1;
      end
      if (ctrl[`IRWD_CTRL_LED_EN] && addr_ok && (ctrl[`IRWD_CTRL_LED_ADDR] || cmd_ok))
      begin
        d.led_cnt = 32'(BLINK_CYC);
        ev[`IRWD_INT_BLINK] = 1'b1;
      end
      if (!(addr_ok && cmd_ok))
      begin
        ev[`IRWD_INT_ERR] = 1'b1;
      end
    end
    if (err)
    begin
      d.st = IRWD_ST_IDLE;
      d.have_half = 1'b0;
      d.pend_mark = 1'b0;
      ev[`IRWD_INT_ERR] = 1'b1;
    end

    if (q.wake_cnt != 16'h0000 && d.wake_cnt == q.wake_cnt)
    begin
      d.wake_cnt = q.wake_cnt - 16'h0001;
    end
    if (q.led_cnt != 32'h0000_0000 && d.led_cnt == q.led_cnt)
    begin
      d.led_cnt = q.led_cnt - 32'h0000_0001;
    end
    d.wake = d.wake_cnt != 16'h0000;
    // blink: lit for the first half of the count
    d.led = d.led_cnt > 32'(BLINK_CYC / 2);

    // apb slave: ready in the first access cycle, held off while loading
    ridx = paddr[7:2];
    rvalid = 1'b1;
    rdata = 32'h0000_0000;
    if (ridx < 6'(`IRWD_NCFG))
    begin
      rdata = q.cfg[ridx[3:0]];
    end
    else if (paddr == `IRWD_OFF_STATUS)
    begin
      rdata = {23'h00_0000, ld.done, q.last_hit, q.last_cmd, q.st};
    end
    else if (paddr == `IRWD_OFF_INT_STAT)
    begin
      rdata = {29'h0000_0000, q.int_stat};
    end
    else if (paddr == `IRWD_OFF_INT_MASK)
    begin
      rdata = {29'h0000_0000, q.int_mask};
    end
    else
    begin
      rvalid = 1'b0;
    end
    if (paddr[1:0] != 2'b00)
    begin
      rvalid = 1'b0;
    end
    d.pready = psel && !q.pready && ld.done;
    if (d.pready)
    begin
      d.prdata = (pwrite || !rvalid) ? 32'h0000_0000 : rdata;
      d.pslverr = !rvalid || (pwrite && paddr == `IRWD_OFF_STATUS);
    end
    else
    begin
      d.pslverr = 1'b0;
    end
    d.int_stat = q.int_stat | ev;
    wr = psel && penable && q.pready && pwrite && !q.pslverr;
    if (wr)
    begin
      if (ridx < 6'(`IRWD_NCFG))
      begin
        d.cfg[ridx[3:0]] = pwdata & cfg_mask(ridx[3:0]);
      end
      else if (paddr == `IRWD_OFF_INT_MASK)
      begin
        d.int_mask = pwdata[2:0];
      end
      else if (paddr == `IRWD_OFF_INT_STAT)
      begin
        // write one clears, a new event in the same cycle wins
        d.int_stat = (q.int_stat & ~pwdata[2:0]) | ev;
      end
    end
    d.irq = |(d.int_stat & d.int_mask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '{st: IRWD_ST_IDLE, default: '0};
    end
    else
    begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign system_wake_pulse = q.wake;
  assign power_led = q.led;
  assign irq = q.irq;
endmodule : irwd_top

// ---- verif/irwd_properties.sv ----
// port-level assertion checker of the ir remote wake decoder, bound into its top
`timescale 1ns/1ns
`include "irwd_consts.svh"
module irwd_properties #(
  parameter int WAKE_CYC = 5,
  parameter int BLINK_CYC = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic system_wake_pulse,
  input wire logic power_led
);
  logic [31:0] wake_n_q;
  logic [31:0] led_n_q;
  logic [4:0] since_q;
  // high-time counters of the two pulse outputs and a saturating age since reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wake_n_q <= '0;
      led_n_q <= '0;
      since_q <= '0;
    end
    else
    begin
      wake_n_q <= system_wake_pulse ? wake_n_q + 32'd1 : 32'd0;
      led_n_q <= power_led ? led_n_q + 32'd1 : 32'd0;
      since_q <= (since_q == 5'd31) ? since_q : since_q + 5'd1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_done;
    psel && penable && pready;
  endsequence
  a_pready_once: assert property (s_done |=> !pready) else $error("pready held");
  a_ready_access: assert property (pready |-> psel && penable) else $error("pready outside access");
  a_answer_first: assert property (s_setup ##1 (penable && since_q == 5'd31) |-> pready)
    else $error("late answer");
  a_err_unmapped: assert property (pready && (paddr[1:0] != 2'b00 || paddr > `IRWD_OFF_INT_MASK ||
    (pwrite && paddr == `IRWD_OFF_STATUS)) |-> pslverr) else $error("missing slave error");
  a_ok_mapped: assert property (pready && paddr[1:0] == 2'b00 && paddr <= `IRWD_OFF_INT_MASK &&
    !(pwrite && paddr == `IRWD_OFF_STATUS) |-> !pslverr) else $error("spurious slave error");
  a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("error read not zero");
  a_wake_width: assert property ($fell(system_wake_pulse) |-> wake_n_q == WAKE_CYC)
    else $error("wake width");
  a_led_width: assert property ($fell(power_led) |-> led_n_q == BLINK_CYC / 2)
    else $error("led width");
  a_load_quiet: assert property (since_q < 5'd8 |-> !pready && !system_wake_pulse)
    else $error("active before load");
endmodule : irwd_properties

bind irwd_top irwd_properties #(.WAKE_CYC(WAKE_CYC), .BLINK_CYC(BLINK_CYC)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .system_wake_pulse(system_wake_pulse), .power_led(power_led));

// ---- verif/irwd_ir_src.sv ----
// behavioural remote control transmitter feeding the demodulated ir line
`timescale 1ns/1ns
module irwd_ir_src #(
  parameter int TICK_CYC = 2,
  parameter int HM = 8,
  parameter int HS = 4,
  parameter int BT = 4,
  parameter int S1 = 8
) (
  input wire logic pclk,
  output logic ir_mark_in
);
  initial ir_mark_in = 1'b0;
  task automatic hold(input logic v, input int t);
    ir_mark_in <= v;
    repeat (t * TICK_CYC) @(posedge pclk);
  endtask : hold
  // bad stretches the header mark beyond the margin
  task automatic send_space(input logic [23:0] d, input int n, input bit hdr, input int bad);
    if (hdr)
    begin
      hold(1'b1, HM + bad);
      hold(1'b0, HS);
    end
    for (int i = n - 1; i >= 0; i--)
    begin
      hold(1'b1, BT);
      hold(1'b0, d[i] ? S1 : BT);
    end
    hold(1'b1, BT);
    hold(1'b0, 16);
  endtask : send_space
  task automatic send_phase(input logic [23:0] d, input int n, input bit inv);
    for (int i = n - 1; i >= 0; i--)
    begin
      hold(d[i] ^ inv, BT);
      hold(!(d[i] ^ inv), BT);
    end
    hold(1'b0, 16);
  endtask : send_phase
endmodule : irwd_ir_src

// ---- verif/irwd_top_tb.sv ----
// self-checking bench of the ir remote wake decoder
`timescale 1ns/1ns
`include "irwd_consts.svh"
`define CHK(g, e) \
  begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module irwd_top_tb;
  import irwd_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, ir_mark_in, system_wake_pulse, power_led, irq;
  int errors = 0;
  int n_tests = 0;
  int n_wake = 0;
  int n_blink = 0;
  logic [31:0] rst_val [11] = '{`IRWD_RST_CTRL, `IRWD_RST_FIELD, `IRWD_RST_ADDR, `IRWD_RST_CMD_LO,
    `IRWD_RST_CMD_HI, `IRWD_RST_CMD_EN, `IRWD_RST_HDR_MARK, `IRWD_RST_HDR_SPACE, `IRWD_RST_BIT_T,
    `IRWD_RST_SPACE1, `IRWD_RST_MARGIN};
  int tv [6] = '{255, 8, 4, 4, 8, 2};
  logic [6:0] sc_ctrl [9] = '{7'h05, 7'h05, 7'h05, 7'h01, 7'h03, 7'h1B, 7'h25, 7'h65, 7'h25};
  // 0 good, 1 wrong address, 2 wrong command, 3 header too long
  int sc_kind [9] = '{0, 1, 3, 0, 0, 0, 0, 2, 2};
  always #5 pclk = ~pclk;
  always @(posedge system_wake_pulse) n_wake++;
  always @(posedge power_led) n_blink++;
  irwd_top #(.WAKE_CYC(5), .BLINK_CYC(20), .TICK_CYC(2)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ir_mark_in(ir_mark_in),
    .system_wake_pulse(system_wake_pulse), .power_led(power_led), .irq(irq));
  irwd_ir_src #(.TICK_CYC(2)) u_ir (.pclk(pclk), .ir_mark_in(ir_mark_in));
  task automatic complete_run();
    if (errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  initial
  begin
    repeat (40000) @(posedge pclk);
    errors++;
    complete_run();
  end
  initial
  begin
    logic [31:0] rd, d;
    logic er;
    logic [7:0] addr, a;
    logic [3:0] c;
    logic [2:0] exp_st, mask;
    logic [6:0] ct;
    int cmds [8];
    int kind, exp_wake, exp_blink;
    bit fm, am, bl;
    exp_wake = 0;
    exp_blink = 0;
    void'($urandom(53));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < `IRWD_NCFG; i++)
    begin
      apb(1'b0, 8'(4 * i), 32'h0000_0000, rd, er);
      `CHK(rd, rst_val[i])
    end
    apb(1'b0, 8'h3C, 32'h0000_0000, rd, er);
    `CHK(er, 1'b1)
    apb(1'b1, `IRWD_OFF_STATUS, 32'h0000_0000, rd, er);
    `CHK(er, 1'b1)
    addr = 8'($urandom) | 8'h80;
    for (int i = 0; i < 8; i++) cmds[i] = $urandom & 7;
    apb(1'b1, `IRWD_OFF_FIELD, 32'h0000_0408, rd, er);
    apb(1'b1, `IRWD_OFF_ADDR, {24'h00_0000, addr}, rd, er);
    for (int h = 0; h < 2; h++)
    begin
      for (int b = 0; b < 4; b++) d[8 * b +: 8] = 8'(cmds[4 * h + b]);
      apb(1'b1, 8'(`IRWD_OFF_CMD_LO + 4 * h), d, rd, er);
    end
    for (int i = 0; i < 6; i++) apb(1'b1, 8'(`IRWD_OFF_CMD_EN + 4 * i), 32'(tv[i]), rd, er);
    for (int k = 0; k < 9; k++)
    begin
      kind = sc_kind[k];
      ct = sc_ctrl[k];
      c = (kind == 2) ? 4'hF : 4'(cmds[$urandom_range(7)]);
      a = addr ^ {8{kind == 1}};
      d = ct[`IRWD_CTRL_CMD_FIRST] ? {20'h0_0000, c, a} : {20'h0_0000, a, c};
      mask = (k == 1) ? 3'b000 : 3'b111;
      apb(1'b1, `IRWD_OFF_INT_MASK, {29'h0, mask}, rd, er);
      apb(1'b1, `IRWD_OFF_CTRL, {25'h0, ct}, rd, er);
      if (ct[`IRWD_CTRL_PHASE])
        u_ir.send_phase(d[23:0], 12, ct[`IRWD_CTRL_INV]);
      else
        u_ir.send_space(d[23:0], 12, ct[`IRWD_CTRL_HDR], (kind == 3) ? 4 : 0);
      fm = (kind == 0);
      am = (kind == 0 || kind == 2);
      bl = ct[`IRWD_CTRL_LED_EN] && (ct[`IRWD_CTRL_LED_ADDR] ? am : fm);
      exp_wake += fm;
      exp_blink += bl;
      exp_st = {!fm, bl, fm};
      repeat (60) @(posedge pclk);
      `CHK(n_wake, exp_wake)
      `CHK(n_blink, exp_blink)
      apb(1'b0, `IRWD_OFF_INT_STAT, 32'h0000_0000, rd, er);
      `CHK(rd[2:0], exp_st)
      `CHK(irq, |(exp_st & mask))
      apb(1'b1, `IRWD_OFF_INT_STAT, 32'h0000_0007, rd, er);
      repeat (2) @(posedge pclk);
      `CHK(irq, 1'b0)
    end
    complete_run();
  end
endmodule : irwd_top_tb
